// [pdet_pkg.sv]
`default_nettype none
package pdet_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CROSS_PERIOD = 8'h0e;
  localparam logic [7:0] OFS_IIR0_HI_L = 8'h0f;
  localparam logic [7:0] OFS_IIR0_HI_H = 8'h10;
  localparam logic [7:0] OFS_IIR0_LO_L = 8'h11;
  localparam logic [7:0] OFS_IIR0_LO_H = 8'h12;
  localparam logic [7:0] OFS_IIR0_FMT = 8'h13;
  localparam logic [7:0] OFS_IIR1_HI_L = 8'h16;
  localparam logic [7:0] OFS_IIR1_HI_H = 8'h17;
  localparam logic [7:0] OFS_IIR1_LO_L = 8'h18;
  localparam logic [7:0] OFS_IIR1_LO_H = 8'h19;
  localparam logic [7:0] OFS_IIR1_FMT = 8'h1a;
  localparam logic [7:0] OFS_HOLD_L = 8'h1d;
  localparam logic [7:0] OFS_HOLD_H = 8'h1e;
  localparam logic [7:0] OFS_RMS_EN = 8'h20;
  localparam logic [7:0] OFS_RMS_BLK = 8'h21;
  localparam logic [7:0] OFS_RMS_HI_L = 8'h22;
  localparam logic [7:0] OFS_RMS_HI_H = 8'h23;
  localparam logic [7:0] OFS_RMS_LO_L = 8'h24;
  localparam logic [7:0] OFS_RMS_LO_H = 8'h25;
  localparam logic [7:0] OFS_GAIN_RESET = 8'h2b;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h41;
  localparam logic [7:0] OFS_FLAGS = 8'h42;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int GAIN_RESET_BIT = 4;
  localparam int BLK_EXP_W = 5;
  localparam int CROSS_EXP_W = 4;
  localparam logic [4:0] BLK_EXP_MAX = 5'h10;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int SAMPLE_DIV = 8;
  localparam logic [2:0] DIV_LAST = 3'h7;
  // Crossing fraction scale: 4000h is all samples, 0800h is one in eight
  localparam logic [15:0] CROSS_FULL = 16'h4000;
  // Status bit positions
  localparam int ST_IIR0_SET = 0;
  localparam int ST_IIR0_CLR = 1;
  localparam int ST_IIR1_SET = 2;
  localparam int ST_IIR1_CLR = 3;
  localparam int ST_RMS_HIGH = 4;
  localparam int ST_RMS_LOW = 5;
endpackage
`default_nettype wire

// [pdet_iir_cmp.sv]
`default_nettype none
module pdet_iir_cmp (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_tick,
  input wire logic signed [15:0] i_level,
  input wire logic signed [15:0] i_upper,
  input wire logic signed [15:0] i_lower,
  input wire logic [15:0] i_hold,
  input wire logic i_two_bit,
  output logic o_flag,
  output logic [1:0] o_code
);
  logic [15:0] cnt_reg;
  logic above;
  logic below;
  assign above = i_level > i_upper;
  assign below = i_level < i_lower;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_flag <= 1'b0;
      cnt_reg <= 16'h0000;
    end else if (i_tick) begin
      if (above) begin
        o_flag <= 1'b1;
        cnt_reg <= 16'h0000;
      end else if (!below) begin
        cnt_reg <= 16'h0000;
      end else if (o_flag) begin
        if (cnt_reg >= i_hold) begin
          o_flag <= 1'b0;
          cnt_reg <= 16'h0000;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
    end
  end
  // Two-bit code: bit1 is the held upper flag, bit0 marks below lower
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_code <= 2'h0;
    end else if (i_tick) begin
      o_code <= i_two_bit ? {o_flag | above, below} : {1'b0, o_flag | above};
    end
  end
endmodule
`default_nettype wire

// [pdet_rms.sv]
`default_nettype none
module pdet_rms (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_tick,
  input wire logic i_enable,
  input wire logic [4:0] i_exp,
  input wire logic [15:0] i_power,
  input wire logic [15:0] i_upper,
  input wire logic [15:0] i_lower,
  output logic [15:0] o_average,
  output logic o_done,
  output logic o_high,
  output logic o_low
);
  logic [32:0] acc_reg;
  logic [16:0] cnt_reg;
  logic [16:0] last;
  logic [4:0] exp_sat;
  logic [32:0] sum;
  assign exp_sat = (i_exp > pdet_pkg::BLK_EXP_MAX) ? pdet_pkg::BLK_EXP_MAX : i_exp;
  assign last = 17'((17'h1 << exp_sat) - 17'h1);
  assign sum = acc_reg + {17'h0, i_power};
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_reg <= 33'h0;
      cnt_reg <= 17'h0;
      o_average <= 16'h0;
      o_done <= 1'b0;
      o_high <= 1'b0;
      o_low <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!i_enable) begin
        acc_reg <= 33'h0;
        cnt_reg <= 17'h0;
        o_high <= 1'b0;
        o_low <= 1'b0;
      end else if (i_tick) begin
        if (cnt_reg >= last) begin
          o_average <= 16'(sum >> exp_sat);
          o_high <= 16'(sum >> exp_sat) > i_upper;
          o_low <= 16'(sum >> exp_sat) < i_lower;
          o_done <= 1'b1;
          acc_reg <= 33'h0;
          cnt_reg <= 17'h0;
        end else begin
          acc_reg <= sum;
          cnt_reg <= cnt_reg + 17'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [pdet_top.sv]
// Operation
// - Two IIR threshold pairs, sixteen bits each
// - Crossing thresholds are signed 2.14 values
// - 4000h means all crossings, linear scale
// - Per-set enable picks one or two bits
// - Flag sets when output exceeds upper level
// - Flag clears after continuous dwell below lower
// - Dwell is 16-bit count of divided clocks
// - Average power runs only while enabled
// - Average block is two to M ticks
// - Average compared with upper and lower levels
// - Power threshold LSB is 2^-16 full scale
// - Crossing period is two to N ticks
//
// Our own choice: the address-and-strobe port.
`default_nettype none
module pdet_top (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_crossing,
  input wire logic [15:0] i_power,
  output logic [7:0] o_rdata,
  output logic [1:0] o_iir0_code,
  output logic [1:0] o_iir1_code,
  output logic o_rms_high,
  output logic o_rms_low,
  output logic o_gain_loop_reset,
  output logic o_irq
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] iir0_upper_level_reg;
  logic [15:0] iir0_lower_level_reg;
  logic [15:0] iir1_upper_level_reg;
  logic [15:0] iir1_lower_level_reg;
  logic [15:0] filter_flag_hold_count_reg;
  logic [15:0] average_power_upper_level_reg;
  logic [15:0] average_power_lower_level_reg;
  logic set0_two_bit_select_reg;
  logic set1_two_bit_select_reg;
  logic average_power_enable_reg;
  logic [4:0] average_block_exponent_reg;
  logic [3:0] crossing_period_exponent_reg;
  logic [5:0] irq_status_reg;
  logic [5:0] irq_status_next;
  logic [5:0] irq_mask_reg;
  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      iir0_upper_level_reg <= {2{pdet_pkg::RESET_BYTE}};
      iir0_lower_level_reg <= {2{pdet_pkg::RESET_BYTE}};
      iir1_upper_level_reg <= {2{pdet_pkg::RESET_BYTE}};
      iir1_lower_level_reg <= {2{pdet_pkg::RESET_BYTE}};
      filter_flag_hold_count_reg <= {2{pdet_pkg::RESET_BYTE}};
      average_power_upper_level_reg <= {2{pdet_pkg::RESET_BYTE}};
      average_power_lower_level_reg <= {2{pdet_pkg::RESET_BYTE}};
      set0_two_bit_select_reg <= 1'b0;
      set1_two_bit_select_reg <= 1'b0;
      average_power_enable_reg <= 1'b0;
      average_block_exponent_reg <= 5'h00;
      crossing_period_exponent_reg <= 4'h0;
      irq_mask_reg <= 6'h00;
      o_gain_loop_reset <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        pdet_pkg::OFS_IIR0_HI_L: iir0_upper_level_reg[7:0] <= i_wdata;
        pdet_pkg::OFS_IIR0_HI_H: iir0_upper_level_reg[15:8] <= i_wdata;
        pdet_pkg::OFS_IIR0_LO_L: iir0_lower_level_reg[7:0] <= i_wdata;
        pdet_pkg::OFS_IIR0_LO_H: iir0_lower_level_reg[15:8] <= i_wdata;
        pdet_pkg::OFS_IIR0_FMT: set0_two_bit_select_reg <= i_wdata[0];
        pdet_pkg::OFS_IIR1_HI_L: iir1_upper_level_reg[7:0] <= i_wdata;
        pdet_pkg::OFS_IIR1_HI_H: iir1_upper_level_reg[15:8] <= i_wdata;
        pdet_pkg::OFS_IIR1_LO_L: iir1_lower_level_reg[7:0] <= i_wdata;
        pdet_pkg::OFS_IIR1_LO_H: iir1_lower_level_reg[15:8] <= i_wdata;
        pdet_pkg::OFS_IIR1_FMT: set1_two_bit_select_reg <= i_wdata[0];
        pdet_pkg::OFS_HOLD_L: filter_flag_hold_count_reg[7:0] <= i_wdata;
        pdet_pkg::OFS_HOLD_H: filter_flag_hold_count_reg[15:8] <= i_wdata;
        pdet_pkg::OFS_RMS_EN: average_power_enable_reg <= i_wdata[0];
        pdet_pkg::OFS_RMS_BLK: average_block_exponent_reg <= i_wdata[4:0];
        pdet_pkg::OFS_RMS_HI_L: average_power_upper_level_reg[7:0] <= i_wdata;
        pdet_pkg::OFS_RMS_HI_H: average_power_upper_level_reg[15:8] <= i_wdata;
        pdet_pkg::OFS_RMS_LO_L: average_power_lower_level_reg[7:0] <= i_wdata;
        pdet_pkg::OFS_RMS_LO_H: average_power_lower_level_reg[15:8] <= i_wdata;
        pdet_pkg::OFS_CROSS_PERIOD: crossing_period_exponent_reg <= i_wdata[3:0];
        pdet_pkg::OFS_GAIN_RESET: o_gain_loop_reset <= i_wdata[pdet_pkg::GAIN_RESET_BIT];
        pdet_pkg::OFS_IRQ_MASK: irq_mask_reg <= i_wdata[5:0];
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Sample clock divided by eight
  // ----------------------------------------------------------------
  logic [2:0] div_reg;
  logic tick;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end
  assign tick = div_reg == pdet_pkg::DIV_LAST;
  // ----------------------------------------------------------------
  // Crossing detector and IIR smoothing
  // ----------------------------------------------------------------
  // The crossing pin is asynchronous, so it passes two flops first
  logic cross_meta_reg;
  logic cross_sync_reg;
  logic [15:0] cross_cnt_reg;
  logic [15:0] period_cnt_reg;
  logic [15:0] period_last;
  logic [16:0] cross_now;
  logic signed [15:0] iir_reg;
  logic signed [15:0] rate;
  logic signed [17:0] iir_step;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cross_meta_reg <= 1'b0;
      cross_sync_reg <= 1'b0;
    end else begin
      cross_meta_reg <= i_crossing;
      cross_sync_reg <= cross_meta_reg;
    end
  end
  assign period_last = 16'((17'h1 << crossing_period_exponent_reg) - 17'h1);
  // The closing tick of a period counts too, else a one-tick period never sees a hit
  assign cross_now = {1'b0, cross_cnt_reg} + {16'h0, cross_sync_reg};
  // Rate in 2.14: crossings scaled so a full period of hits gives 4000h
  assign rate = 16'(({15'h0, cross_now} * {16'h0, pdet_pkg::CROSS_FULL})
                    >> crossing_period_exponent_reg);
  // First-order IIR: a quarter step toward the new rate per period
  assign iir_step = 18'(18'(signed'(rate)) - 18'(iir_reg)) >>> 2;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cross_cnt_reg <= 16'h0;
      period_cnt_reg <= 16'h0;
      iir_reg <= 16'sh0;
    end else if (tick) begin
      if (period_cnt_reg >= period_last) begin
        period_cnt_reg <= 16'h0;
        cross_cnt_reg <= 16'h0;
        iir_reg <= 16'(iir_reg + 16'(iir_step));
      end else begin
        period_cnt_reg <= period_cnt_reg + 16'h1;
        cross_cnt_reg <= cross_cnt_reg + {15'h0, cross_sync_reg};
      end
    end
  end
  // ----------------------------------------------------------------
  // Comparator sets
  // ----------------------------------------------------------------
  logic flag0;
  logic flag1;
  pdet_iir_cmp u_set0 (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_tick(tick),
    .i_level(iir_reg),
    .i_upper(iir0_upper_level_reg),
    .i_lower(iir0_lower_level_reg),
    .i_hold(filter_flag_hold_count_reg),
    .i_two_bit(set0_two_bit_select_reg),
    .o_flag(flag0),
    .o_code(o_iir0_code)
  );
  pdet_iir_cmp u_set1 (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_tick(tick),
    .i_level(iir_reg),
    .i_upper(iir1_upper_level_reg),
    .i_lower(iir1_lower_level_reg),
    .i_hold(filter_flag_hold_count_reg),
    .i_two_bit(set1_two_bit_select_reg),
    .o_flag(flag1),
    .o_code(o_iir1_code)
  );
  // ----------------------------------------------------------------
  // Average power
  // ----------------------------------------------------------------
  logic rms_done;
  pdet_rms u_rms (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_tick(tick),
    .i_enable(average_power_enable_reg),
    .i_exp(average_block_exponent_reg),
    .i_power(i_power),
    .i_upper(average_power_upper_level_reg),
    .i_lower(average_power_lower_level_reg),
    .o_average(),
    .o_done(rms_done),
    .o_high(o_rms_high),
    .o_low(o_rms_low)
  );
  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic flag0_d_reg;
  logic flag1_d_reg;
  logic [5:0] events;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flag0_d_reg <= 1'b0;
      flag1_d_reg <= 1'b0;
    end else begin
      flag0_d_reg <= flag0;
      flag1_d_reg <= flag1;
    end
  end
  assign events = {rms_done & o_rms_low, rms_done & o_rms_high,
                   flag1_d_reg & ~flag1, flag1 & ~flag1_d_reg,
                   flag0_d_reg & ~flag0, flag0 & ~flag0_d_reg};
  // A read clears the status, but an event in the same cycle survives
  always_comb begin
    irq_status_next = irq_status_reg;
    if (i_rd && i_addr == pdet_pkg::OFS_IRQ_STATUS) begin
      irq_status_next = 6'h00;
    end
    irq_status_next = irq_status_next | events;
  end
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_status_reg <= 6'h00;
      o_irq <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      o_irq <= |(irq_status_next & irq_mask_reg);
    end
  end
  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        pdet_pkg::OFS_IIR0_HI_L: o_rdata <= iir0_upper_level_reg[7:0];
        pdet_pkg::OFS_IIR0_HI_H: o_rdata <= iir0_upper_level_reg[15:8];
        pdet_pkg::OFS_IIR0_LO_L: o_rdata <= iir0_lower_level_reg[7:0];
        pdet_pkg::OFS_IIR0_LO_H: o_rdata <= iir0_lower_level_reg[15:8];
        pdet_pkg::OFS_IIR0_FMT: o_rdata <= {7'h00, set0_two_bit_select_reg};
        pdet_pkg::OFS_IIR1_HI_L: o_rdata <= iir1_upper_level_reg[7:0];
        pdet_pkg::OFS_IIR1_HI_H: o_rdata <= iir1_upper_level_reg[15:8];
        pdet_pkg::OFS_IIR1_LO_L: o_rdata <= iir1_lower_level_reg[7:0];
        pdet_pkg::OFS_IIR1_LO_H: o_rdata <= iir1_lower_level_reg[15:8];
        pdet_pkg::OFS_IIR1_FMT: o_rdata <= {7'h00, set1_two_bit_select_reg};
        pdet_pkg::OFS_HOLD_L: o_rdata <= filter_flag_hold_count_reg[7:0];
        pdet_pkg::OFS_HOLD_H: o_rdata <= filter_flag_hold_count_reg[15:8];
        pdet_pkg::OFS_RMS_EN: o_rdata <= {7'h00, average_power_enable_reg};
        pdet_pkg::OFS_RMS_BLK: o_rdata <= {3'h0, average_block_exponent_reg};
        pdet_pkg::OFS_RMS_HI_L: o_rdata <= average_power_upper_level_reg[7:0];
        pdet_pkg::OFS_RMS_HI_H: o_rdata <= average_power_upper_level_reg[15:8];
        pdet_pkg::OFS_RMS_LO_L: o_rdata <= average_power_lower_level_reg[7:0];
        pdet_pkg::OFS_RMS_LO_H: o_rdata <= average_power_lower_level_reg[15:8];
        pdet_pkg::OFS_CROSS_PERIOD: o_rdata <= {4'h0, crossing_period_exponent_reg};
        pdet_pkg::OFS_GAIN_RESET: o_rdata <= {3'h0, o_gain_loop_reset, 4'h0};
        pdet_pkg::OFS_IRQ_STATUS: o_rdata <= {2'h0, irq_status_reg};
        pdet_pkg::OFS_IRQ_MASK: o_rdata <= {2'h0, irq_mask_reg};
        pdet_pkg::OFS_FLAGS: o_rdata <= {o_rms_low, o_rms_high, 4'h0, flag1, flag0};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// [pdet_props.sv]
`default_nettype none
module pdet_props (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_crossing,
  input wire logic [15:0] i_power,
  input wire logic [7:0] o_rdata,
  input wire logic [1:0] o_iir0_code,
  input wire logic [1:0] o_iir1_code,
  input wire logic o_rms_high,
  input wire logic o_rms_low,
  input wire logic o_gain_loop_reset,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // ----------------------------------------------------------------
  // Shadow of the control bits the properties depend on
  // ----------------------------------------------------------------
  logic en_reg;
  logic fmt0_reg;
  logic fmt1_reg;
  logic gain_reg;
  logic [7:0] mask_reg;
  logic [4:0] off_cnt_reg;
  logic [4:0] one0_cnt_reg;
  logic [4:0] one1_cnt_reg;
  logic [4:0] nomask_cnt_reg;
  function automatic logic [4:0] sat(input logic [4:0] c, input logic cond);
    return !cond ? 5'h00 : (c == 5'h1f) ? c : c + 5'h01;
  endfunction
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      en_reg <= 1'b0;
      fmt0_reg <= 1'b0;
      fmt1_reg <= 1'b0;
      gain_reg <= 1'b0;
      mask_reg <= 8'h00;
    end else if (i_wr) begin
      if (i_addr == pdet_pkg::OFS_RMS_EN) en_reg <= i_wdata[0];
      if (i_addr == pdet_pkg::OFS_IIR0_FMT) fmt0_reg <= i_wdata[0];
      if (i_addr == pdet_pkg::OFS_IIR1_FMT) fmt1_reg <= i_wdata[0];
      if (i_addr == pdet_pkg::OFS_GAIN_RESET) gain_reg <= i_wdata[4];
      if (i_addr == pdet_pkg::OFS_IRQ_MASK) mask_reg <= i_wdata;
    end
  end
  // Settling counters: outputs update on the divided tick, so allow slack
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      off_cnt_reg <= 5'h00;
      one0_cnt_reg <= 5'h00;
      one1_cnt_reg <= 5'h00;
      nomask_cnt_reg <= 5'h00;
    end else begin
      off_cnt_reg <= sat(off_cnt_reg, !en_reg);
      one0_cnt_reg <= sat(one0_cnt_reg, !fmt0_reg);
      one1_cnt_reg <= sat(one1_cnt_reg, !fmt1_reg);
      nomask_cnt_reg <= sat(nomask_cnt_reg, mask_reg == 8'h00);
    end
  end
  chk_rdata_idle_zero: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not zero when idle");
  chk_enable_readback: assert property (
    i_rd && i_addr == pdet_pkg::OFS_RMS_EN |=> o_rdata == {7'h00, en_reg})
    else $error("enable register read back wrong");
  chk_gain_bit_write: assert property (
    i_wr && i_addr == pdet_pkg::OFS_GAIN_RESET |=> o_gain_loop_reset == gain_reg)
    else $error("gain loop reset not taken from write");
  chk_gain_bit_hold: assert property (
    !(i_wr && i_addr == pdet_pkg::OFS_GAIN_RESET) |=> $stable(o_gain_loop_reset))
    else $error("gain loop reset changed without write");
  chk_set0_one_bit: assert property (
    one0_cnt_reg >= 5'd24 |-> o_iir0_code[1] == 1'b0) else $error("set0 upper bit in 1-bit mode");
  chk_set1_one_bit: assert property (
    one1_cnt_reg >= 5'd24 |-> o_iir1_code[1] == 1'b0) else $error("set1 upper bit in 1-bit mode");
  chk_rms_off_quiet: assert property (
    off_cnt_reg >= 5'd16 |-> !o_rms_high && !o_rms_low) else $error("average flags while disabled");
  chk_irq_masked_off: assert property (
    nomask_cnt_reg >= 5'd2 |-> !o_irq) else $error("interrupt with all sources masked");
  chk_code_tick_hold: assert property (
    $changed(o_iir0_code) |=> $stable(o_iir0_code)[*7]) else $error("code changed between ticks");
  cover property ($rose(o_iir0_code[0]));
  cover property (o_iir1_code == 2'b11);
  cover property ($rose(o_rms_high));
  cover property ($rose(o_irq));
endmodule
bind pdet_top pdet_props i_props (.i_clk_sys, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_crossing, .i_power, .o_rdata, .o_iir0_code, .o_iir1_code, .o_rms_high, .o_rms_low,
  .o_gain_loop_reset, .o_irq);
`default_nettype wire

// [pdet_tb_top.sv]
`default_nettype none
module pdet_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_crossing = 1'b0;
  logic [15:0] i_power = 16'h0000;
  logic [7:0] o_rdata;
  logic [1:0] o_iir0_code;
  logic [1:0] o_iir1_code;
  logic o_rms_high;
  logic o_rms_low;
  logic o_gain_loop_reset;
  logic o_irq;
  int err_total = 0;
  int tests_run = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  pdet_top i_dut (.i_clk_sys, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .i_crossing,
    .i_power, .o_rdata, .o_iir0_code, .o_iir1_code, .o_rms_high, .o_rms_low,
    .o_gain_loop_reset, .o_irq);
  // ----------------------------------------------------------------
  // Bus and comparison helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    chk({8'h00, o_rdata}, {8'h00, exp});
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask
  task automatic ticks(input int n);
    repeat (n * pdet_pkg::SAMPLE_DIV) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] ofs [14] = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h16, 8'h17, 8'h18, 8'h19,
      8'h1d, 8'h1e, 8'h22, 8'h23, 8'h24, 8'h25};
    foreach (ofs[k]) rd_chk(ofs[k], 8'h00);
    rd_chk(8'h13, 8'h00);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h21, 8'h00);
    foreach (ofs[k]) wr(ofs[k], ofs[k] + 8'h41);
    foreach (ofs[k]) rd_chk(ofs[k], ofs[k] + 8'h41);
    wr(8'h13, 8'hff);
    wr(8'h1a, 8'hff);
    wr(8'h21, 8'h10);
    wr(8'h30, 8'hff);
    rd_chk(8'h13, 8'h01);
    rd_chk(8'h1a, 8'h01);
    rd_chk(8'h21, 8'h10);
    rd_chk(8'h30, 8'h00);
    $display("register test done");
  endtask
  task automatic t_gain();
    wr(8'h2b, 8'h10);
    #1;
    chk({15'h0, o_gain_loop_reset}, 16'h0001);
    rd_chk(8'h2b, 8'h10);
    wr(8'h2b, 8'h00);
    #1;
    chk({15'h0, o_gain_loop_reset}, 16'h0000);
    $display("gain loop reset test done");
  endtask
  task automatic t_iir();
    wr16(8'h0f, 16'h2000);
    wr16(8'h11, 16'h1000);
    wr16(8'h16, 16'h2000);
    wr16(8'h18, 16'h1000);
    wr16(8'h1d, 16'h0100);
    wr(8'h13, 8'h00);
    wr(8'h1a, 8'h01);
    wr(8'h0e, 8'h00);
    wr(8'h41, 8'h00);
    rd_chk(8'h40, 8'h00);
    i_crossing <= 1'b1;
    ticks(60);
    chk({14'h0, o_iir0_code}, 16'h0001);
    chk({14'h0, o_iir1_code}, 16'h0002);
    rd_chk(8'h42, 8'h03);
    chk({15'h0, o_irq}, 16'h0000);
    wr(8'h41, 8'h05);
    repeat (3) @(posedge i_clk_sys);
    #1;
    chk({15'h0, o_irq}, 16'h0001);
    rd_chk(8'h40, 8'h05);
    repeat (3) @(posedge i_clk_sys);
    #1;
    chk({15'h0, o_irq}, 16'h0000);
    i_crossing <= 1'b0;
    ticks(200);
    chk({14'h0, o_iir0_code}, 16'h0001);
    chk({14'h0, o_iir1_code}, 16'h0003);
    ticks(100);
    chk({14'h0, o_iir0_code}, 16'h0000);
    chk({14'h0, o_iir1_code}, 16'h0001);
    rd_chk(8'h40, 8'h0a);
    $display("threshold and hold test done");
  endtask
  task automatic t_rms();
    wr16(8'h22, 16'h1000);
    wr16(8'h24, 16'h0800);
    wr(8'h21, 8'h02);
    i_power <= 16'h2000;
    wr(8'h20, 8'h01);
    ticks(15);
    chk({14'h0, o_rms_high, o_rms_low}, 16'h0002);
    i_power <= 16'h0400;
    ticks(15);
    chk({14'h0, o_rms_high, o_rms_low}, 16'h0001);
    rd_chk(8'h40, 8'h30);
    wr(8'h20, 8'h00);
    ticks(3);
    chk({14'h0, o_rms_high, o_rms_low}, 16'h0000);
    $display("average power test done");
  endtask
  initial begin
    repeat (30000) @(posedge i_clk_sys);
    err_total++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    t_regs();
    t_gain();
    t_iir();
    t_rms();
    conclude();
  end
endmodule
`default_nettype wire
